// >>> shared/mscd_defs.vh
`ifndef MSCD_DEFS_VH
`define MSCD_DEFS_VH

// ==========================================================
// register offsets (word index on the register port)
`define MSCD_ADDR_W          5
`define MSCD_OFS_SRC_DIR     5'h08
`define MSCD_OFS_ACCEL       5'h09
`define MSCD_OFS_INPUT_TYPE  5'h0a
`define MSCD_OFS_STARTUP     5'h0b
`define MSCD_OFS_OBS_P       5'h0c
`define MSCD_OFS_OBS_I       5'h0d
`define MSCD_OFS_OUT_PIN     5'h0e
`define MSCD_OFS_POS_DETECT  5'h12
`define MSCD_OFS_NUDGE_OFF   5'h15
`define MSCD_OFS_RESP_RATIO  5'h16
`define MSCD_OFS_STATUS      5'h1f

// ==========================================================
// reset value of every configuration register
`define MSCD_CFG_RESET       16'h0000
// speed feedback pin level while disabled and in reset
`define MSCD_FB_PIN_IDLE     1'b1

// ==========================================================
// field positions
`define MSCD_B_CLOSED_LOOP   11
`define MSCD_B_CLOCK_FMT     12
`define MSCD_B_RAMP_SCALE    13
`define MSCD_B_PHASE_ORDER   14
`define MSCD_B_PWM_RANGE     15
`define MSCD_B_SRC_SELECT    11
`define MSCD_B_FB_DISABLE    4
`define MSCD_F_ACCEL         7:0
`define MSCD_F_STARTUP       11:10
`define MSCD_F_OBS_GAIN      7:0
`define MSCD_F_POS_LIMIT     13:8
`define MSCD_F_NUDGE         7:5
`define MSCD_F_OFF_THRESH    9:8
`define MSCD_F_RESP_RATIO    5:0

// ==========================================================
// startup method codes
`define MSCD_START_SIX       2'h0
`define MSCD_START_TWO       2'h1
`define MSCD_START_NUDGE     2'h2
`define MSCD_START_ALIGN     2'h3

// off threshold codes and their percentages
`define MSCD_OFF_CODE_0      2'h0
`define MSCD_OFF_CODE_1      2'h1
`define MSCD_OFF_CODE_2      2'h2
`define MSCD_OFF_PCT_0       7'h0a
`define MSCD_OFF_PCT_1       7'h06
`define MSCD_OFF_PCT_2       7'h0f
`define MSCD_OFF_PCT_3       7'h14

// ==========================================================
// scaling: ramp in 0.05 Hz/s steps, high range is 64 steps per lsb
`define MSCD_RAMP_HI_SHIFT   6
// position detect threshold in mA per lsb
`define MSCD_POS_MA_PER_LSB  13'h0056
// nudge amplitude in 0.1 % units: 32 per lsb plus 24
`define MSCD_NUDGE_PER_LSB   8'h20
`define MSCD_NUDGE_OFFSET    8'h18
// legal range of the response/ratio field
`define MSCD_RATIO_MIN       6'h01
`define MSCD_RATIO_MAX       6'h29

`endif

// >>> hdl/mscd_phase_seq.v
`timescale 1ns/10ps
`include "mscd_defs.vh"

module mscd_phase_seq (
  // clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // control
  input  wire       step,
  input  wire       fwdOrder,
  // phase one-hot {C,B,A}
  output reg  [2:0] phaseSel
);

  // ==========================================================
  // states
  localparam [2:0] PH_A = 3'h1;
  localparam [2:0] PH_B = 3'h2;
  localparam [2:0] PH_C = 3'h4;

  // ==========================================================
  // advance one phase per step, order picked per step so a
  // direction change takes effect on the very next commutation
  always @(posedge clock) begin
    if (sys_rst) begin
      phaseSel <= PH_A;
    end else if (step) begin
      case (phaseSel)
        PH_A: begin
          phaseSel <= fwdOrder ? PH_B : PH_C; // R17
        end
        PH_B: begin
          phaseSel <= fwdOrder ? PH_C : PH_A; // R17
        end
        PH_C: begin
          phaseSel <= fwdOrder ? PH_A : PH_B; // R17
        end
        default: begin
          phaseSel <= PH_A; // recover from an illegal code
        end
      endcase
    end
  end

endmodule // mscd_phase_seq

// >>> hdl/mscd_speed_cfg.v
`timescale 1ns/10ps
`include "mscd_defs.vh"

// Behaviour
// [R01] speed loop bit selects closed or open loop
// [R02] source bit one picks analog, else digital
// [R03] format bit one means clock, else PWM
// [R04] range bit one means PWM up to 2.8kHz
// [R05] ramp rate is field times 0.05 or 3.2
// [R06] closed loop time constant is field over 15
// [R07] open loop ignores response field for dynamics
// [R08] clock mode rpm is frequency times field quarter
// [R09] host keeps response field within 1 to 41
// [R10] two-bit code selects off threshold percentage
// [R11] disable bit holds speed feedback pin high
// [R12] two-bit code selects the startup method
// [R13] position detect current is field times 0.086A
// [R14] nudge amplitude is field times 3.2 plus 2.4
// [R15] eight-bit field is observer proportional gain
// [R16] eight-bit field is observer integral gain
// [R17] order bit picks ABC or ACB commutation
// [R18] demand under off threshold stops the motor

module mscd_speed_cfg #(
  parameter FREQ_W = 16,
  parameter PCT_W  = 7
) (
  // clock and reset
  input  wire                  clock,
  input  wire                  sys_rst,
  // register port (decoded host accesses)
  input  wire [`MSCD_ADDR_W-1:0] regAddr,
  input  wire                  regWrEn,
  input  wire [15:0]           regWrData,
  input  wire                  regRdEn,
  output reg  [15:0]           regRdData,
  // speed demand sources, in percent, and the clock input frequency in Hz
  input  wire [PCT_W-1:0]      analogDemand,
  input  wire [PCT_W-1:0]      pwmDuty,
  input  wire [PCT_W-1:0]      clkDemand,
  input  wire [FREQ_W-1:0]     clkInFreqHz,
  // commutation and feedback
  input  wire                  phaseStep,
  input  wire                  feedbackLevel,
  // speed mode outputs
  output reg                   closedLoopEn,
  output reg                   analogSel,
  output reg                   clockFmtSel,
  output reg                   pwmLowRange,
  output reg  [13:0]           rampRate,
  output reg  [5:0]            respTc,
  output reg  [FREQ_W+5:0]     targetRpmQ,
  output reg  [PCT_W-1:0]      offThreshPct,
  output reg                   motorRun,
  output reg                   ratioBad,
  // startup and observer outputs
  output reg  [3:0]            startupSel,
  output reg  [12:0]           posDetectLimitMa,
  output reg  [7:0]            nudgeAmp,
  output reg  [7:0]            observerPropGain,
  output reg  [7:0]            observerIntegGain,
  // pins
  output reg                   speedFeedbackPin,
  output wire [2:0]            phaseSel
);

  // ==========================================================
  // configuration storage
  // every index reads safely; only the ten mapped words are ever written
  reg  [15:0] cfgMem [0:31];
  wire [15:0] srcDir;
  wire [15:0] accelCfg;
  wire [15:0] inputType;
  wire [15:0] startupCfg;
  wire [15:0] obsPCfg;
  wire [15:0] obsICfg;
  wire [15:0] outPinCfg;
  wire [15:0] posCfg;
  wire [15:0] nudgeOffCfg;
  wire [15:0] respCfg;

  // only the mapped offsets hold storage
  // the status word is read only, so it is not listed here
  function isMapped;
    input [`MSCD_ADDR_W-1:0] a;
    begin
      case (a)
        `MSCD_OFS_SRC_DIR,
        `MSCD_OFS_ACCEL,
        `MSCD_OFS_INPUT_TYPE,
        `MSCD_OFS_STARTUP,
        `MSCD_OFS_OBS_P,
        `MSCD_OFS_OBS_I,
        `MSCD_OFS_OUT_PIN,
        `MSCD_OFS_POS_DETECT,
        `MSCD_OFS_NUDGE_OFF,
        `MSCD_OFS_RESP_RATIO: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // one write process per entry; unmapped entries stay at reset
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : gEntry
      // sized copy of the index, so compare and lookup see address width
      localparam [`MSCD_ADDR_W-1:0] ENTRY = gi;
      always @(posedge clock) begin
        if (sys_rst) begin
          cfgMem[gi] <= `MSCD_CFG_RESET;
        end else if (regWrEn && (regAddr == ENTRY) && isMapped(ENTRY)) begin
          cfgMem[gi] <= regWrData;
        end
      end
    end
  endgenerate

  assign srcDir      = cfgMem[`MSCD_OFS_SRC_DIR];
  assign accelCfg    = cfgMem[`MSCD_OFS_ACCEL];
  assign inputType   = cfgMem[`MSCD_OFS_INPUT_TYPE];
  assign startupCfg  = cfgMem[`MSCD_OFS_STARTUP];
  assign obsPCfg     = cfgMem[`MSCD_OFS_OBS_P];
  assign obsICfg     = cfgMem[`MSCD_OFS_OBS_I];
  assign outPinCfg   = cfgMem[`MSCD_OFS_OUT_PIN];
  assign posCfg      = cfgMem[`MSCD_OFS_POS_DETECT];
  assign nudgeOffCfg = cfgMem[`MSCD_OFS_NUDGE_OFF];
  assign respCfg     = cfgMem[`MSCD_OFS_RESP_RATIO];

  // ==========================================================
  // decoded mode bits
  // bit 11 means loop select in one word and source select in another
  wire       loopBit   = srcDir[`MSCD_B_CLOSED_LOOP];
  wire       fmtBit    = srcDir[`MSCD_B_CLOCK_FMT];
  wire       scaleBit  = srcDir[`MSCD_B_RAMP_SCALE];
  wire       orderBit  = srcDir[`MSCD_B_PHASE_ORDER];
  wire       rangeBit  = srcDir[`MSCD_B_PWM_RANGE];
  wire       srcBit    = inputType[`MSCD_B_SRC_SELECT];
  wire       fbDisable = outPinCfg[`MSCD_B_FB_DISABLE];
  wire [7:0] accel     = accelCfg[`MSCD_F_ACCEL];
  wire [1:0] startCode = startupCfg[`MSCD_F_STARTUP];
  wire [5:0] posField  = posCfg[`MSCD_F_POS_LIMIT];
  wire [2:0] nudgeFld  = nudgeOffCfg[`MSCD_F_NUDGE];
  wire [1:0] offCode   = nudgeOffCfg[`MSCD_F_OFF_THRESH];
  wire [5:0] ratio     = respCfg[`MSCD_F_RESP_RATIO];

  // ==========================================================
  // arithmetic, all integer so no divider is needed: outputs
  // carry fixed units, scaled where each one is used
  wire [13:0]       rampLo   = {6'h00, accel};
  // eight bits shifted by six fill fourteen exactly, so nothing is lost
  wire [13:0]       rampHi   = {6'h00, accel} << `MSCD_RAMP_HI_SHIFT;
  // a zero ratio gives zero rpm; ratioBad reports it, the decode does not
  wire [FREQ_W+5:0] rpmProd  = clkInFreqHz * ratio;
  wire [12:0]       posProd  = {7'h00, posField} * `MSCD_POS_MA_PER_LSB;
  wire [7:0]        nudgeVal = ({5'h00, nudgeFld} * `MSCD_NUDGE_PER_LSB)
                               + `MSCD_NUDGE_OFFSET;
  wire              isClock  = !srcBit && fmtBit;

  // ==========================================================
  // off threshold lookup
  // the codes do not rise in order: code 1 is the lowest threshold
  reg [PCT_W-1:0] offPct;
  always @* begin
    case (offCode)
      `MSCD_OFF_CODE_0: offPct = `MSCD_OFF_PCT_0; // R10
      `MSCD_OFF_CODE_1: offPct = `MSCD_OFF_PCT_1; // R10
      `MSCD_OFF_CODE_2: offPct = `MSCD_OFF_PCT_2; // R10
      default:          offPct = `MSCD_OFF_PCT_3; // R10
    endcase
  end

  // ==========================================================
  // demand source mux: analog, else clock or PWM
  // the format bit is ignored while the analog source is chosen
  reg [PCT_W-1:0] demand;
  always @* begin
    if (srcBit) begin
      demand = analogDemand; // R02
    end else if (fmtBit) begin
      demand = clkDemand; // R03
    end else begin
      demand = pwmDuty; // R03
    end
  end

  // ==========================================================
  // startup method one-hot {align, nudge, two, six}
  localparam [3:0] START_HOT_SIX   = 4'h1;
  localparam [3:0] START_HOT_TWO   = 4'h2;
  localparam [3:0] START_HOT_NUDGE = 4'h4;
  localparam [3:0] START_HOT_ALIGN = 4'h8;

  reg [3:0] startOneHot;
  always @* begin
    case (startCode)
      `MSCD_START_SIX:   startOneHot = START_HOT_SIX; // R12
      `MSCD_START_TWO:   startOneHot = START_HOT_TWO; // R12
      `MSCD_START_NUDGE: startOneHot = START_HOT_NUDGE; // R12
      default:           startOneHot = START_HOT_ALIGN; // R12
    endcase
  end

  // ==========================================================
  // registered speed mode outputs
  always @(posedge clock) begin
    if (sys_rst) begin
      closedLoopEn <= 1'b0;
      analogSel    <= 1'b0;
      clockFmtSel  <= 1'b0;
      pwmLowRange  <= 1'b0;
      rampRate     <= 14'h0000;
      respTc       <= 6'h00;
      targetRpmQ   <= {(FREQ_W+6){1'b0}};
      offThreshPct <= `MSCD_OFF_PCT_0;
      motorRun     <= 1'b0;
      ratioBad     <= 1'b0;
    end else begin
      closedLoopEn <= loopBit; // R01
      analogSel    <= srcBit; // R02
      clockFmtSel  <= fmtBit; // R03
      pwmLowRange  <= rangeBit; // R04
      rampRate     <= scaleBit ? rampHi : rampLo; // R05
      // open loop forces zero so nothing downstream sees a constant
      respTc       <= loopBit ? ratio : 6'h00; // R06 R07
      // rpm in quarter-rpm units, only meaningful in clock mode
      targetRpmQ   <= isClock ? rpmProd : {(FREQ_W+6){1'b0}}; // R08
      offThreshPct <= offPct; // R10
      // stop below threshold; equal counts as running
      motorRun     <= (demand >= offPct); // R18
      // field only matters in closed loop or clock mode
      // the flag only reports; the decode still uses the field as written
      ratioBad     <= (loopBit || isClock) &&
                      ((ratio < `MSCD_RATIO_MIN) || (ratio > `MSCD_RATIO_MAX)); // R09
    end
  end

  // ==========================================================
  // registered startup, observer and pin outputs
  always @(posedge clock) begin
    if (sys_rst) begin
      startupSel        <= START_HOT_SIX;
      posDetectLimitMa  <= 13'h0000;
      nudgeAmp          <= 8'h00;
      observerPropGain  <= 8'h00;
      observerIntegGain <= 8'h00;
      speedFeedbackPin  <= `MSCD_FB_PIN_IDLE;
    end else begin
      startupSel        <= startOneHot; // R12
      posDetectLimitMa  <= posProd; // R13
      // amplitude demand only while slight-move startup is chosen
      nudgeAmp          <= (startCode == `MSCD_START_NUDGE) ? nudgeVal : 8'h00; // R14
      // gains pass through; their scaling belongs to the observer
      observerPropGain  <= obsPCfg[`MSCD_F_OBS_GAIN]; // R15
      observerIntegGain <= obsICfg[`MSCD_F_OBS_GAIN]; // R16
      // held high keeps the shared pin quiet for host traffic
      speedFeedbackPin  <= fbDisable ? `MSCD_FB_PIN_IDLE : feedbackLevel; // R11
    end
  end

  // ==========================================================
  // commutation order
  // the order bit is read at every step, so a change needs no restart
  mscd_phase_seq uPhase (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .step     (phaseStep),
    .fwdOrder (orderBit),
    .phaseSel (phaseSel)
  );

  // ==========================================================
  // status word: {ratio bad, run, nudge chosen, phase, closed loop}
  // nudge flag comes from the stored code, so it leads startupSel by a cycle
  wire        nudgeChosen = (startOneHot == START_HOT_NUDGE);
  wire [15:0] statusWord  = {9'h000, ratioBad, motorRun, nudgeChosen,
                             phaseSel, loopBit};

  // ==========================================================
  // read selection: status word, storage, zero elsewhere
  reg [15:0] rdSel;
  always @* begin
    if (regAddr == `MSCD_OFS_STATUS) begin
      rdSel = statusWord;
    end else if (isMapped(regAddr)) begin
      rdSel = cfgMem[regAddr];
    end else begin
      rdSel = 16'h0000; // unmapped reads return zero
    end
  end

  // ==========================================================
  // read data holds until the next read strobe
  always @(posedge clock) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      regRdData <= rdSel;
    end
  end

endmodule // mscd_speed_cfg

// >>> verif/mscd_speed_cfg_props.sv
`timescale 1ns/10ps
`include "mscd_defs.vh"

module mscd_speed_cfg_props (
  // clock, reset and register port
  input wire        clock,
  input wire        sys_rst,
  input wire [4:0]  regAddr,
  input wire        regWrEn,
  input wire [15:0] regWrData,
  // decoded outputs
  input wire        closedLoopEn,
  input wire        analogSel,
  input wire        clockFmtSel,
  input wire        pwmLowRange,
  input wire [3:0]  startupSel,
  input wire [12:0] posDetectLimitMa,
  input wire [7:0]  observerPropGain,
  input wire [7:0]  observerIntegGain,
  input wire        speedFeedbackPin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // write taken, then a quiet cycle so a later write cannot overtake the decode
  sequence s_wr(logic [4:0] a);
    regWrEn && regAddr == a ##1 !regWrEn;
  endsequence

  // ==========================================================
  // field decode lands one edge after the write edge and is checked at the edge after that
  a_loop_mode: assert property (s_wr(`MSCD_OFS_SRC_DIR) |-> ##1
    closedLoopEn == $past(regWrData[11], 2)) else $error("loop mode decode wrong");
  a_src_sel: assert property (s_wr(`MSCD_OFS_INPUT_TYPE) |-> ##1
    analogSel == $past(regWrData[11], 2)) else $error("source select decode wrong");
  a_fmt_sel: assert property (s_wr(`MSCD_OFS_SRC_DIR) |-> ##1
    clockFmtSel == $past(regWrData[12], 2)) else $error("format decode wrong");
  a_pwm_range: assert property (s_wr(`MSCD_OFS_SRC_DIR) |-> ##1
    pwmLowRange == $past(regWrData[15], 2)) else $error("pwm range decode wrong");
  a_startup_hot: assert property (s_wr(`MSCD_OFS_STARTUP) |-> ##1
    startupSel == 4'h1 << $past(regWrData[11:10], 2)) else $error("startup decode wrong");
  a_pos_limit: assert property (s_wr(`MSCD_OFS_POS_DETECT) |-> ##1
    posDetectLimitMa == $past(regWrData[13:8], 2) * 13'h0056) else $error("limit wrong");
  a_obs_prop: assert property (s_wr(`MSCD_OFS_OBS_P) |-> ##1
    observerPropGain == $past(regWrData[7:0], 2)) else $error("prop gain wrong");
  a_obs_integ: assert property (s_wr(`MSCD_OFS_OBS_I) |-> ##1
    observerIntegGain == $past(regWrData[7:0], 2)) else $error("integ gain wrong");
  // pin is high for two cycles once the disable write has been decoded
  a_fb_high: assert property (s_wr(`MSCD_OFS_OUT_PIN) ##0 $past(regWrData[4]) |->
    ##1 speedFeedbackPin [*2]) else $error("feedback pin not held high");
endmodule // mscd_speed_cfg_props

bind mscd_speed_cfg mscd_speed_cfg_props i_mscd_speed_cfg_props (
  .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .closedLoopEn(closedLoopEn), .analogSel(analogSel),
  .clockFmtSel(clockFmtSel), .pwmLowRange(pwmLowRange), .startupSel(startupSel),
  .posDetectLimitMa(posDetectLimitMa), .observerPropGain(observerPropGain),
  .observerIntegGain(observerIntegGain), .speedFeedbackPin(speedFeedbackPin));

// >>> verif/mscd_host_model.sv
`timescale 1ns/10ps
`include "mscd_defs.vh"

module mscd_host_model (
  // clock
  input  wire         clock,
  // register port toward the device
  output logic [4:0]  regAddr,
  output logic        regWrEn,
  output logic [15:0] regWrData,
  output logic        regRdEn,
  input  wire  [15:0] regRdData
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    regAddr = 5'h00;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    regRdEn = 1'b0;
  end

  // one write, then quiet cycles so decoded outputs have landed on return
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == `MSCD_OFS_RESP_RATIO && (d[5:0] < `MSCD_RATIO_MIN || d[5:0] > `MSCD_RATIO_MAX))
      d[5:0] = `MSCD_RATIO_MIN;
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
    regWrData = ~d; // released data does not keep its last value
    repeat (2) @(negedge clock);
  endtask

  // read data is registered one edge after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    d = regRdData;
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule // mscd_host_model

// >>> verif/mscd_speed_cfg_tb_top.sv
`timescale 1ns/10ps
`include "mscd_defs.vh"

module mscd_speed_cfg_tb_top;
  logic clock, sys_rst, phaseStep, feedbackLevel;
  logic [6:0]  analogDemand, pwmDuty, clkDemand;
  logic [15:0] clkInFreqHz, rdv;
  wire  [4:0]  regAddr;
  wire         regWrEn, regRdEn, closedLoopEn, analogSel, clockFmtSel, pwmLowRange;
  wire         motorRun, ratioBad, speedFeedbackPin;
  wire  [15:0] regWrData, regRdData;
  wire  [13:0] rampRate;
  wire  [5:0]  respTc;
  wire  [21:0] targetRpmQ;
  wire  [6:0]  offThreshPct;
  wire  [3:0]  startupSel;
  wire  [12:0] posDetectLimitMa;
  wire  [7:0]  nudgeAmp, observerPropGain, observerIntegGain;
  wire  [2:0]  phaseSel;
  int nMismatch = 0;
  int samplesChecked = 0;
  logic [4:0] ofs [10] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h12, 5'h15, 5'h16};
  logic [6:0] pct [4] = '{7'h0a, 7'h06, 7'h0f, 7'h14};

  mscd_host_model i_mscd_host_model (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  mscd_speed_cfg i_mscd_speed_cfg (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .analogDemand(analogDemand), .pwmDuty(pwmDuty), .clkDemand(clkDemand),
    .clkInFreqHz(clkInFreqHz), .phaseStep(phaseStep), .feedbackLevel(feedbackLevel),
    .closedLoopEn(closedLoopEn), .analogSel(analogSel), .clockFmtSel(clockFmtSel),
    .pwmLowRange(pwmLowRange), .rampRate(rampRate), .respTc(respTc),
    .targetRpmQ(targetRpmQ), .offThreshPct(offThreshPct), .motorRun(motorRun),
    .ratioBad(ratioBad), .startupSel(startupSel), .posDetectLimitMa(posDetectLimitMa),
    .nudgeAmp(nudgeAmp), .observerPropGain(observerPropGain),
    .observerIntegGain(observerIntegGain), .speedFeedbackPin(speedFeedbackPin),
    .phaseSel(phaseSel));

  // ==========================================================
  // clock, checking and ending
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (nMismatch == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    i_mscd_host_model.wr(a, d);
  endtask

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    nMismatch++;
    end_of_test();
  end

  // ==========================================================
  // main sequence, inputs move only at falling edges
  initial begin
    sys_rst = 1'b1;
    {phaseStep, feedbackLevel} = 2'b00;
    {analogDemand, pwmDuty, clkDemand} = {7'h09, 7'h50, 7'h50};
    clkInFreqHz = 16'h03e8;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk({offThreshPct, startupSel, speedFeedbackPin, phaseSel}, {7'h0a, 4'h1, 1'b1, 3'h1});
    // readback of every configuration register, plus an unmapped place that must stay empty
    for (int i = 0; i < 10; i++) begin
      i_mscd_host_model.rd(ofs[i], rdv);
      chk(rdv, `MSCD_CFG_RESET);
      wr(ofs[i], 16'ha500 + i + 1);
      i_mscd_host_model.rd(ofs[i], rdv);
      chk(rdv, 16'ha500 + i + 1);
    end
    wr(5'h10, 16'hffff);
    i_mscd_host_model.rd(5'h10, rdv);
    chk(rdv, 16'h0000);
    // ramp scale, both ranges of the same field
    wr(5'h09, 16'h00ff);
    wr(5'h08, 16'h2000);
    chk(rampRate, 14'h3fc0);
    wr(5'h08, 16'h9000);
    chk({rampRate, pwmLowRange, clockFmtSel}, {14'h00ff, 2'b11});
    // ratio field: time constant only in closed loop, rpm ratio in clock mode
    wr(5'h0a, 16'h0000);
    wr(5'h16, 16'h0029);
    chk({respTc, targetRpmQ, ratioBad}, {6'h00, 22'h00_a028, 1'b0});
    wr(5'h08, 16'h1800);
    chk({closedLoopEn, respTc}, {1'b1, 6'h29});
    // off threshold codes and startup codes with the nudge amplitude
    for (int i = 0; i < 4; i++) begin
      wr(5'h15, (i << 8) | 16'h00e0);
      wr(5'h0b, i << 10);
      chk(offThreshPct, pct[i]);
      chk({startupSel, nudgeAmp}, {4'h1 << i, (i == 2) ? 8'hf8 : 8'h00});
    end
    wr(5'h12, 16'h3f00);
    chk(posDetectLimitMa, 13'h152a);
    wr(5'h0c, 16'h00a5);
    wr(5'h0d, 16'h005a);
    chk({observerPropGain, observerIntegGain}, 16'ha55a);
    wr(5'h0e, 16'h0010);
    chk(speedFeedbackPin, 1'b1);
    wr(5'h0e, 16'h0000);
    chk(speedFeedbackPin, 1'b0);
    feedbackLevel = 1'b1;
    repeat (2) @(negedge clock);
    chk(speedFeedbackPin, 1'b1);
    // analog source against the 10 % threshold, then the digital pwm source
    wr(5'h15, 16'h0000);
    wr(5'h0a, 16'h0800);
    chk({analogSel, motorRun}, 2'b10);
    analogDemand = 7'h0a;
    repeat (3) @(negedge clock);
    chk(motorRun, 1'b1);
    wr(5'h08, 16'h0000);
    wr(5'h0a, 16'h0000);
    pwmDuty = 7'h05;
    repeat (3) @(negedge clock);
    chk({analogSel, motorRun}, 2'b00);
    wr(5'h08, 16'h1000);
    chk({clockFmtSel, motorRun}, 2'b11);
    // commutation order, forward then reverse from B
    wr(5'h08, 16'h4000);
    phaseStep = 1'b1;
    @(negedge clock);
    phaseStep = 1'b0;
    chk(phaseSel, 3'h2);
    wr(5'h08, 16'h0000);
    phaseStep = 1'b1;
    @(negedge clock);
    phaseStep = 1'b0;
    chk(phaseSel, 3'h1);
    @(negedge clock);
    phaseStep = 1'b1;
    @(negedge clock);
    phaseStep = 1'b0;
    chk(phaseSel, 3'h4);
    // mid-run reset, then closed loop while the ratio field is back at zero
    {sys_rst, feedbackLevel} = 2'b10;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk({offThreshPct, startupSel, speedFeedbackPin, phaseSel}, {7'h0a, 4'h1, 1'b1, 3'h1});
    wr(5'h08, 16'h0800);
    chk({closedLoopEn, ratioBad}, 2'b11);
    i_mscd_host_model.rd(5'h1f, rdv);
    chk(rdv, 16'h0043);
    end_of_test();
  end
endmodule // mscd_speed_cfg_tb_top
